// File: mode_select_map.svh
// offsets, fields, reset values and timing counts of the mode selector
//----------------------------------------------------------------
// Overview of operation
//----------------------------------------------------------------
// Overview of operation
// - preset speed runs forward with direction input off, reverse when on.
// - selects off/off stop, off/on speed 1, on/on speed 2, on/off speed 3.
// - codes 4-6 pair preset speed; 7-9 loop pairs; A and B clamp, inhibit.
// - codes 4-6 default pins: both selects off runs the loop, else preset.
// - loop control may switch into preset speed while the motor turns.
// - a select input change is taken within 2 ms, soft start aside.
// - preset to position decelerates first, position only after stopping.
// - codes 4-6 custom pins: method input on runs loop, off preset.
// - custom preset takes direction and speed from dedicated inputs.
// - codes 7-9 default: mode switch on speed/torque/speed, off pos/pos/tq.
// - codes 7-9 custom: method input gets the same on and off mapping.
// - presets 0 to 10000 rpm, motor maximum replaces larger values.
`ifndef MODE_SELECT_MAP_SVH
`define MODE_SELECT_MAP_SVH

// register byte offsets
`define REG_CONFIG 8'h00
`define REG_APPLY 8'h04
`define REG_SPEED_ONE 8'h08
`define REG_SPEED_TWO 8'h0C
`define REG_SPEED_THREE 8'h10
`define REG_DECEL 8'h14
`define REG_STATUS 8'h18

// config fields
`define CFG_CODE_LSB 0
`define CFG_CODE_MSB 3
`define CFG_ALLOC_BIT 4

// reset values
`define CFG_CODE_RST 4'h0
`define CFG_ALLOC_RST 1'b0
`define SPEED_ONE_RST 14'h0064
`define SPEED_TWO_RST 14'h00C8
`define SPEED_THREE_RST 14'h012C
`define DECEL_RST 16'h0000
`define SPEED_LIMIT 14'h2710

// select latency bound, in ns, and in clocks at 25 MHz
`define SEL_LATENCY_NS 2000000
`define CLK_PERIOD_NS 40
`define SEL_LATENCY_CYC (`SEL_LATENCY_NS / `CLK_PERIOD_NS)

`endif

// File: mode_select_pkg.sv
// types shared by the mode selector
package mode_select_pkg;

  // active control method
  typedef enum logic [2:0] {
    CM_SPEED = 3'h0,
    CM_POSITION = 3'h1,
    CM_TORQUE = 3'h2,
    CM_PRESET = 3'h3,
    CM_ZCLAMP = 3'h4,
    CM_INHIBIT = 3'h5
  } ctrl_mode_t;

  // handover phase, gray along run -> decel -> run
  typedef enum logic [1:0] {
    PH_RUN = 2'b00,
    PH_DECEL = 2'b01
  } phase_t;

  // synchronised inputs, 1 = on
  typedef struct packed {
    logic mode_sw;
    logic sel_a;
    logic sel_b;
    logic p_dir;
    logic p_a;
    logic p_b;
    logic method;
  } sel_pins_t;

endpackage

// File: mode_select.sv
// control method and preset speed selection with wishbone registers
//
// The address map and register access over Wishbone are this design's own decisions.
`include "mode_select_map.svh"

module mode_select
  import mode_select_pkg::*;
#(
  parameter logic [13:0] MOTOR_MAX_RPM = 14'd6000
) (
  input wire logic sys_clk, // 25 MHz clock
  input wire logic resetn, // async reset, low active
  // wishbone slave
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_we_i, // write enable
  input wire logic [7:0] wb_adr_i, // byte address
  input wire logic [3:0] wb_sel_i, // byte lanes
  input wire logic [31:0] wb_dat_i, // write data
  output logic [31:0] wb_dat_o, // read data
  output logic wb_ack_o, // acknowledge
  // discrete inputs, active low pins
  input wire logic mode_switch_dir_in_n, // mode switch / direction
  input wire logic fwd_limit_sel_a_in_n, // select a, default pins
  input wire logic rev_limit_sel_b_in_n, // select b, default pins
  input wire logic preset_direction_in_n, // direction, custom pins
  input wire logic preset_select_a_in_n, // select a, custom pins
  input wire logic preset_select_b_in_n, // select b, custom pins
  input wire logic method_select_in_n, // method select, custom
  // from the speed loop, same clock
  input wire logic motor_stopped_in, // motor at standstill
  // towards the loops
  output ctrl_mode_t ctrl_mode, // active control method
  output logic [13:0] preset_speed_ref, // preset speed, rpm
  output logic preset_reverse, // preset direction reverse
  output logic decel_active, // ramping down before position
  output logic [15:0] decel_time_ms // ramp time for the ramp
);

  //----------------------------------------------------------------
  // helpers
  //----------------------------------------------------------------

  // a/b select decode to preset index, 0 means stop
  function automatic logic [1:0] preset_index(input logic a,
                                              input logic b);
    unique case ({a, b})
      2'b00: preset_index = 2'd0;
      2'b01: preset_index = 2'd1;
      2'b11: preset_index = 2'd2;
      2'b10: preset_index = 2'd3;
    endcase
  endfunction

  // clip a written speed to the range, then to the motor
  function automatic logic [13:0] speed_clip(input logic [31:0] v);
    logic [13:0] r;
    r = (v > 32'(`SPEED_LIMIT)) ? `SPEED_LIMIT : v[13:0];
    speed_clip = (r > MOTOR_MAX_RPM) ? MOTOR_MAX_RPM : r;
  endfunction

  //----------------------------------------------------------------
  // input synchroniser
  //----------------------------------------------------------------

  sel_pins_t meta_reg, sync_reg, pin_lvl, on_now;

  // raw pin levels, wiring only: no gate sits ahead of the first flop
  assign pin_lvl = '{mode_sw: mode_switch_dir_in_n,
                     sel_a: fwd_limit_sel_a_in_n,
                     sel_b: rev_limit_sel_b_in_n,
                     p_dir: preset_direction_in_n,
                     p_a: preset_select_a_in_n,
                     p_b: preset_select_b_in_n,
                     method: method_select_in_n};

  // two stages, reset to the idle high pin level; only sync_reg is read
  // two flop sync
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      meta_reg <= '1;
      sync_reg <= '1;
    end else begin
      meta_reg <= pin_lvl;
      sync_reg <= meta_reg;
    end
  end

  // inversion after the second stage: on = pin low
  // active low to on
  assign on_now = ~sync_reg;

  //----------------------------------------------------------------
  // register file
  //----------------------------------------------------------------

  logic [3:0] code_stage_reg, code_stage_next;
  logic alloc_stage_reg, alloc_stage_next;
  logic [3:0] code_reg, code_next;
  logic alloc_reg, alloc_next;
  logic [13:0] spd1_reg, spd1_next;
  logic [13:0] spd2_reg, spd2_next;
  logic [13:0] spd3_reg, spd3_next;
  logic [15:0] decel_reg, decel_next;
  logic ack_reg, ack_next;
  logic [31:0] rdata_reg, rdata_next;
  logic bus_hit, wr_go;
  logic [31:0] status_word;

  ctrl_mode_t mode_reg, mode_next;
  phase_t phase_reg, phase_next;
  logic [13:0] spd_ref_reg, spd_ref_next;
  logic rev_reg, rev_next;

  // answer one cycle after the strobe, drop after one cycle
  assign bus_hit = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr_go = bus_hit & wb_we_i;
  assign status_word = {21'h00_0000, phase_reg, rev_reg,
                        alloc_reg, code_reg, mode_reg};

  // decode writes and reads; byte lanes gate each field
  always_comb begin
    code_stage_next = code_stage_reg;
    alloc_stage_next = alloc_stage_reg;
    code_next = code_reg;
    alloc_next = alloc_reg;
    spd1_next = spd1_reg;
    spd2_next = spd2_reg;
    spd3_next = spd3_reg;
    decel_next = decel_reg;
    ack_next = bus_hit;
    rdata_next = rdata_reg;
    if (wr_go && wb_sel_i[0]) begin
      unique case (wb_adr_i)
        `REG_CONFIG: begin
          code_stage_next = wb_dat_i[`CFG_CODE_MSB:`CFG_CODE_LSB];
          alloc_stage_next = wb_dat_i[`CFG_ALLOC_BIT];
        end
        // staged setting only acts on this restart strobe
        `REG_APPLY: begin
          if (wb_dat_i[0]) begin
            code_next = code_stage_reg;
            alloc_next = alloc_stage_reg;
          end
        end
        default: ;
      endcase
    end
    // speeds need both low lanes, a torn value would jump
    if (wr_go && (&wb_sel_i[1:0])) begin
      unique case (wb_adr_i)
        `REG_SPEED_ONE: spd1_next = speed_clip(wb_dat_i);
        `REG_SPEED_TWO: spd2_next = speed_clip(wb_dat_i);
        `REG_SPEED_THREE: spd3_next = speed_clip(wb_dat_i);
        `REG_DECEL: decel_next = wb_dat_i[15:0];
        default: ;
      endcase
    end
    if (bus_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        `REG_CONFIG: rdata_next = {27'h000_0000, alloc_stage_reg,
                                   code_stage_reg};
        `REG_SPEED_ONE: rdata_next = {18'h0_0000, spd1_reg};
        `REG_SPEED_TWO: rdata_next = {18'h0_0000, spd2_reg};
        `REG_SPEED_THREE: rdata_next = {18'h0_0000, spd3_reg};
        `REG_DECEL: rdata_next = {16'h0000, decel_reg};
        `REG_STATUS: rdata_next = status_word;
        default: rdata_next = 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // register file state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      code_stage_reg <= `CFG_CODE_RST;
      alloc_stage_reg <= `CFG_ALLOC_RST;
      code_reg <= `CFG_CODE_RST;
      alloc_reg <= `CFG_ALLOC_RST;
      spd1_reg <= `SPEED_ONE_RST;
      spd2_reg <= `SPEED_TWO_RST;
      spd3_reg <= `SPEED_THREE_RST;
      decel_reg <= `DECEL_RST;
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      code_stage_reg <= code_stage_next;
      alloc_stage_reg <= alloc_stage_next;
      code_reg <= code_next;
      alloc_reg <= alloc_next;
      spd1_reg <= spd1_next;
      spd2_reg <= spd2_next;
      spd3_reg <= spd3_next;
      decel_reg <= decel_next;
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  //----------------------------------------------------------------
  // mode decode
  //----------------------------------------------------------------

  logic dir_on, sel_a_on, sel_b_on, switch_on;
  logic [1:0] idx;
  ctrl_mode_t want;
  logic [13:0] want_spd;

  // pick the pin set by allocation; both stay in sync
  // custom preset pins
  assign dir_on = alloc_reg ? on_now.p_dir : on_now.mode_sw;
  assign sel_a_on = alloc_reg ? on_now.p_a : on_now.sel_a;
  assign sel_b_on = alloc_reg ? on_now.p_b : on_now.sel_b;
  assign switch_on = alloc_reg ? on_now.method : on_now.mode_sw;
  assign idx = preset_index(sel_a_on, sel_b_on);

  // wanted method from code and inputs
  always_comb begin
    want = CM_SPEED;
    unique case (code_reg)
      4'h1: want = CM_POSITION;
      4'h2: want = CM_TORQUE;
      4'h3: want = CM_PRESET;
      4'h4, 4'h5, 4'h6: begin
        if (alloc_reg ? !on_now.method : (idx != 2'd0))
          want = CM_PRESET;
        else if (code_reg == 4'h5)
          want = CM_POSITION;
        else if (code_reg == 4'h6)
          want = CM_TORQUE;
        else
          want = CM_SPEED;
      end
      4'h7: want = switch_on ? CM_SPEED : CM_POSITION;
      4'h8: want = switch_on ? CM_TORQUE : CM_POSITION;
      4'h9: want = switch_on ? CM_SPEED : CM_TORQUE;
      4'hA: want = switch_on ? CM_ZCLAMP : CM_SPEED;
      4'hB: want = switch_on ? CM_INHIBIT : CM_POSITION;
      default: want = CM_SPEED; // codes with no pairing run speed
    endcase
  end

  // speed per index; index 0 is the zero speed stop
  always_comb begin
    unique case (idx)
      2'd1: want_spd = spd1_reg;
      2'd2: want_spd = spd2_reg;
      2'd3: want_spd = spd3_reg;
      default: want_spd = 14'h0000;
    endcase
  end

  //----------------------------------------------------------------
  // method handover
  //----------------------------------------------------------------

  // entering preset is immediate even while turning; only
  // preset to position waits for standstill
  always_comb begin
    mode_next = mode_reg;
    phase_next = phase_reg;
    spd_ref_next = spd_ref_reg;
    rev_next = dir_on;
    unique case (phase_reg)
      PH_RUN: begin
        if (mode_reg == CM_PRESET && want == CM_POSITION) begin
          phase_next = PH_DECEL;
          spd_ref_next = 14'h0000;
        end else begin
          mode_next = want;
          spd_ref_next = (want == CM_PRESET) ? want_spd : 14'h0000;
        end
      end
      PH_DECEL: begin
        spd_ref_next = 14'h0000;
        if (want != CM_POSITION) begin
          // request withdrawn, resume the wanted method
          phase_next = PH_RUN;
          mode_next = want;
          spd_ref_next = (want == CM_PRESET) ? want_spd : 14'h0000;
        end else if (motor_stopped_in) begin
          phase_next = PH_RUN;
          mode_next = CM_POSITION;
        end
      end
      default: phase_next = PH_RUN;
    endcase
  end

  // handover state
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mode_reg <= CM_SPEED;
      phase_reg <= PH_RUN;
      spd_ref_reg <= 14'h0000;
      rev_reg <= 1'b0;
    end else begin
      mode_reg <= mode_next;
      phase_reg <= phase_next;
      spd_ref_reg <= spd_ref_next;
      rev_reg <= rev_next;
    end
  end

  //----------------------------------------------------------------
  // outputs, all from flops
  //----------------------------------------------------------------

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;
  assign ctrl_mode = mode_reg;
  assign preset_speed_ref = spd_ref_reg;
  assign preset_reverse = rev_reg;
  assign decel_active = phase_reg[0]; // only the decel code has bit 0 set
  assign decel_time_ms = decel_reg;

endmodule // mode_select

// File: mode_select_asserts.sv
// port-level assertions for the mode selector
module mode_select_asserts
  import mode_select_pkg::*;
#(
  parameter logic [13:0] MOTOR_MAX_RPM = 14'd6000
) (
  input wire logic sys_clk, // clock
  input wire logic resetn, // async reset
  input wire logic wb_cyc_i, // bus cycle
  input wire logic wb_stb_i, // strobe
  input wire logic wb_ack_o, // acknowledge
  input wire logic motor_stopped_in, // standstill
  input wire ctrl_mode_t ctrl_mode, // active method
  input wire logic [13:0] preset_speed_ref, // preset speed
  input wire logic decel_active // ramp down
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // ----
  // bus, handover, speed limit and method range checks
  // ----
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  chk_ack_answer: assert property
    (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  chk_ref_idle: assert property
    (ctrl_mode != CM_PRESET |-> preset_speed_ref == 14'h0)
    else $error("speed outside preset");
  chk_decel_hold: assert property
    (decel_active |-> ctrl_mode == CM_PRESET && preset_speed_ref == 14'h0)
    else $error("ramp state wrong");
  chk_decel_exit: assert property
    (decel_active && motor_stopped_in |=> !decel_active)
    else $error("ramp not left");
  chk_pos_entry: assert property
    (ctrl_mode == CM_PRESET ##1 ctrl_mode == CM_POSITION
     |-> $past(motor_stopped_in))
    else $error("position while turning");
  chk_ref_limit: assert property
    (preset_speed_ref <= MOTOR_MAX_RPM)
    else $error("speed above limit");
  chk_mode_legal: assert property (ctrl_mode <= CM_INHIBIT)
    else $error("illegal method");
endmodule // mode_select_asserts

bind mode_select mode_select_asserts #(.MOTOR_MAX_RPM(MOTOR_MAX_RPM)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .motor_stopped_in(motor_stopped_in), .ctrl_mode(ctrl_mode),
  .preset_speed_ref(preset_speed_ref), .decel_active(decel_active));

// File: host_pins.sv
// host controller model driving the active low sequence inputs
module host_pins
  import mode_select_pkg::*;
(
  input wire sel_pins_t on_pins, // wanted on states
  output logic mode_switch_dir_in_n, // mode switch
  output logic fwd_limit_sel_a_in_n, // select a
  output logic rev_limit_sel_b_in_n, // select b
  output logic preset_direction_in_n, // custom direction
  output logic preset_select_a_in_n, // custom select a
  output logic preset_select_b_in_n, // custom select b
  output logic method_select_in_n // method select
);
  timeunit 1ns;
  timeprecision 1ns;
  assign mode_switch_dir_in_n = ~on_pins.mode_sw;
  assign fwd_limit_sel_a_in_n = ~on_pins.sel_a;
  assign rev_limit_sel_b_in_n = ~on_pins.sel_b;
  assign preset_direction_in_n = ~on_pins.p_dir;
  assign preset_select_a_in_n = ~on_pins.p_a;
  assign preset_select_b_in_n = ~on_pins.p_b;
  assign method_select_in_n = ~on_pins.method;
endmodule // host_pins

// File: mode_select_tb.sv
// self-checking bench for the mode selector
module mode_select_tb
  import mode_select_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, stop = 1;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, q, rd;
  logic ack, rev, dec, mw, sa, sb, pd, pa, pb, ms;
  logic [13:0] ref_o;
  logic [15:0] dtm;
  ctrl_mode_t mode;
  sel_pins_t on_pins = '0;
  int error_cnt = 0, compares = 0;
  logic [13:0] sp [4] = '{14'h0, 14'h1388, 14'h012C, 14'h00C8};
  ctrl_mode_t on_m [5] = '{CM_SPEED, CM_TORQUE, CM_SPEED, CM_ZCLAMP,
    CM_INHIBIT};
  ctrl_mode_t off_m [5] = '{CM_POSITION, CM_POSITION, CM_TORQUE, CM_SPEED,
    CM_POSITION};

  host_pins HOST (.on_pins(on_pins), .mode_switch_dir_in_n(mw),
    .fwd_limit_sel_a_in_n(sa), .rev_limit_sel_b_in_n(sb),
    .preset_direction_in_n(pd), .preset_select_a_in_n(pa),
    .preset_select_b_in_n(pb), .method_select_in_n(ms));
  mode_select #(.MOTOR_MAX_RPM(14'd5000)) DUT (.sys_clk(sys_clk),
    .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(q),
    .wb_ack_o(ack), .mode_switch_dir_in_n(mw), .fwd_limit_sel_a_in_n(sa),
    .rev_limit_sel_b_in_n(sb), .preset_direction_in_n(pd),
    .preset_select_a_in_n(pa), .preset_select_b_in_n(pb),
    .method_select_in_n(ms), .motor_stopped_in(stop), .ctrl_mode(mode),
    .preset_speed_ref(ref_o), .preset_reverse(rev), .decel_active(dec),
    .decel_time_ms(dtm));

  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  // ----
  // helpers
  // ----
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %0h seen %0h", n, e, s);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    @(posedge sys_clk);
    while (ack !== 1'b1) @(posedge sys_clk);
    rd = q;
    cyc <= 0;
    stb <= 0;
  endtask
  // pins pass two flops, outputs follow on the third edge
  task setp(input sel_pins_t p);
    @(posedge sys_clk);
    on_pins <= p;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task apply(input logic [3:0] c, input logic al);
    bus(1, 8'h00, {27'h000_0000, al, c});
    bus(1, 8'h04, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  // ----
  // scenarios
  // ----
  task t_regs;
    chk("mode", mode, CM_SPEED);
    bus(0, 8'h0C, 0);
    chk("speed2", rd, 32'h0000_00C8);
    bus(0, 8'h1C, 0);
    chk("unmapped", rd, 32'h0);
    bus(1, 8'h08, 32'h0000_1B58);
    bus(0, 8'h08, 0);
    chk("clip", rd, 32'h0000_1388);
    bus(1, 8'h14, 32'h0000_01F4);
    chk("decel", dtm, 32'h0000_01F4);
    bus(1, 8'h00, 32'h0000_0015);
    bus(0, 8'h00, 0);
    chk("config", rd, 32'h0000_0015);
    chk("staged", mode, CM_SPEED);
    $display("t_regs done");
  endtask
  task t_preset;
    apply(4'h4, 1'b0);
    for (int i = 0; i < 8; i++) begin
      setp(sel_pins_t'({i[2:0], 4'h0}));
      chk("mode", mode, (i[1:0] != 0) ? CM_PRESET : CM_SPEED);
      chk("speed", ref_o, sp[i[1:0]]);
      if (i[1:0] != 0) chk("reverse", rev, i[2]);
    end
    $display("t_preset done");
  endtask
  task t_combos;
    setp('0);
    apply(4'h5, 1'b0);
    chk("code5", mode, CM_POSITION);
    apply(4'h6, 1'b0);
    chk("code6", mode, CM_TORQUE);
    for (int i = 0; i < 5; i++) begin
      apply(4'(7 + i), 1'b0);
      setp(7'h40);
      chk("sw on", mode, on_m[i]);
      setp('0);
      chk("sw off", mode, off_m[i]);
    end
    apply(4'h3, 1'b0);
    chk("code3", mode, CM_PRESET);
    chk("code3 spd", ref_o, 32'h0000_0000);
    $display("t_combos done");
  endtask
  task t_custom;
    setp(7'h0F);
    apply(4'h5, 1'b1);
    chk("method on", mode, CM_POSITION);
    setp(7'h0E);
    chk("method off", mode, CM_PRESET);
    chk("c speed", ref_o, sp[3]);
    chk("c rev", rev, 1'b1);
    setp(7'h01);
    repeat (2) @(posedge sys_clk);
    chk("back", mode, CM_POSITION);
    apply(4'h7, 1'b1);
    chk("c7 on", mode, CM_SPEED);
    setp('0);
    chk("c7 off", mode, CM_POSITION);
    $display("t_custom done");
  endtask
  task t_decel;
    apply(4'h5, 1'b0);
    @(posedge sys_clk);
    stop <= 0;
    setp(7'h10);
    chk("run", ref_o, sp[1]);
    setp('0);
    repeat (5) @(posedge sys_clk);
    chk("ramp", dec, 1'b1);
    chk("ramp mode", mode, CM_PRESET);
    chk("ramp spd", ref_o, 32'h0000_0000);
    bus(0, 8'h18, 0);
    chk("status", rd, 32'h0000_022B);
    @(posedge sys_clk);
    stop <= 1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk("stopped", mode, CM_POSITION);
    chk("ramp end", dec, 1'b0);
    @(posedge sys_clk);
    stop <= 0;
    setp(7'h20);
    chk("turning", mode, CM_PRESET);
    chk("turn spd", ref_o, sp[2]);
    $display("t_decel done");
  endtask

  task complete_run;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence after two cycles of reset
  initial begin
    repeat (2) @(posedge sys_clk);
    resetn <= 1;
    t_regs;
    t_preset;
    t_combos;
    t_custom;
    t_decel;
    complete_run;
  end
  // watchdog, far beyond the few hundred cycles needed
  initial begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    complete_run;
  end
endmodule // mode_select_tb
